/* instruction_timing_decoder.sv */
`timescale 1ns/100ps
`include "cpu_timing_defines.svh"
// Functional notes
// - MOVC A,@A+PC: one byte, 3 cycles, code byte at next PC plus A.
// - MOVX forms: one byte, 3 cycles; @Ri 8-bit, @data_pointer 16-bit address.
// - PUSH and POP direct: two bytes, 2 cycles.
// - XCH register 1 cycle, direct/indirect 2; XCHD swaps low nibble, 2 cycles.
// - Carry ops one byte one cycle; direct bit ops two bytes two cycles.
// - ANL/ORL of bit or complement into Carry: two bytes, 2 cycles.
// - JC/JNC: two bytes, 2 cycles not taken, 3 taken.
// - JB/JNB/JBC: three bytes, 3/4 cycles; JBC clears a set bit.
// - ACALL/AJMP: 11-bit target in next instruction's 2K page, 2 bytes, 3 cycles.
// - LCALL/LJMP: 16-bit absolute target, three bytes, 4 cycles.
// - SJMP: unconditional two-byte relative jump, 3 cycles.
// - JMP @A+data_pointer: one byte, 3 cycles, target A plus pointer.
// - JZ/JNZ test A for zero; two bytes, 2 not taken, 3 taken.
// - CJNE three bytes; A and register forms 3/4, indirect form 4/5.
// - DJNZ register 2 bytes 2/3; direct 3 bytes 3/4; decrement then test.
// - NOP and opcode 0xA5: one byte, one cycle, no operation.
// - Relative offsets are signed 8-bit, added to next instruction address.
// - Direct operand 0x00-0x7F is data RAM, 0x80-0xFF special function registers.
// - Program and data spaces are separate; instruction type picks the space.
// - Flash program memory is one block 0x0000 to 0x1FFF.
// - Program memory writable by MOVX only when program_store_control bit 0 set.
// - MOVX reaches on-chip program Flash; no external memory exists.
// - R0-R7 map to one of four banks in 0x00-0x1F by two select bits.
// - Indirect above 0x7F reaches upper RAM; direct there reaches special registers.
module instruction_timing_decoder (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic instr_valid_in,
	input wire cpu_timing_pkg::byte_t opcode_in,
	input wire cpu_timing_pkg::byte_t operand1_in,
	input wire cpu_timing_pkg::byte_t operand2_in,
	input wire cpu_timing_pkg::addr_t instr_addr_in,
	input wire cpu_timing_pkg::byte_t acc_in,
	input wire cpu_timing_pkg::addr_t data_pointer_in,
	input wire logic carry_in,
	input wire logic bit_value_in,
	input wire cpu_timing_pkg::byte_t operand_value_in,
	input wire cpu_timing_pkg::byte_t ri_value_in,
	input wire logic bank_select_low_in,
	input wire logic bank_select_high_in,
	input wire cpu_timing_pkg::byte_t program_store_control_in,
	output logic ready_out,
	output logic done_out,
	output cpu_timing_pkg::bytes_t instr_bytes_out,
	output cpu_timing_pkg::cycles_t instr_cycles_out,
	output logic branch_taken_out,
	output cpu_timing_pkg::addr_t target_addr_out,
	output logic code_read_out,
	output cpu_timing_pkg::addr_t code_addr_out,
	output logic movx_read_out,
	output logic movx_write_out,
	output logic flash_write_out,
	output cpu_timing_pkg::addr_t movx_addr_out,
	output logic factory_area_out,
	output cpu_timing_pkg::byte_t data_addr_out,
	output logic data_sfr_out,
	output logic bit_clear_out,
	output logic low_nibble_xch_out,
	output logic nop_out,
	output logic unlisted_out
);
	import cpu_timing_pkg::*;

	function automatic addr_t add_offset(input addr_t base, input byte_t off, input logic sign_ext);
		addr_t ext;
		ext = {{8{sign_ext & off[7]}}, off};
		return base + ext;
	endfunction

	// ***************************************************
	// Opcode decode
	// ***************************************************
	byte_t op_even;
	byte_t op_bank;
	assign op_even = {opcode_in[7:1], 1'b0};
	assign op_bank = {opcode_in[7:3], 3'h0};
	wire movc_pc_w = opcode_in == `OP_MOVC_PC;
	wire movc_dp_w = opcode_in == `OP_MOVC_DP;
	wire movx_rd_w = (op_even == `OP_MOVX_RD_RI) || (opcode_in == `OP_MOVX_RD_DP);
	wire movx_wr_w = (op_even == `OP_MOVX_WR_RI) || (opcode_in == `OP_MOVX_WR_DP);
	wire movx_dp_w = (opcode_in == `OP_MOVX_RD_DP) || (opcode_in == `OP_MOVX_WR_DP);
	wire stack_w = (opcode_in == `OP_PUSH) || (opcode_in == `OP_POP);
	wire xch_reg_w = op_bank == `OP_XCH_REG;
	wire xch_dir_w = opcode_in == `OP_XCH_DIR;
	wire xch_ind_w = op_even == `OP_XCH_IND;
	wire xchd_w = op_even == `OP_XCHD;
	wire carry_op_w = (opcode_in == `OP_CLR_C) || (opcode_in == `OP_SETB_C) || (opcode_in == `OP_CPL_C);
	wire bit_op_w = (opcode_in == `OP_CLR_BIT) || (opcode_in == `OP_SETB_BIT) || (opcode_in == `OP_CPL_BIT)
		|| (opcode_in == `OP_MOV_C_BIT) || (opcode_in == `OP_MOV_BIT_C);
	wire bit_logic_w = (opcode_in == `OP_ANL_C_BIT) || (opcode_in == `OP_ANL_C_NBIT)
		|| (opcode_in == `OP_ORL_C_BIT) || (opcode_in == `OP_ORL_C_NBIT);
	wire jc_w = opcode_in == `OP_JC;
	wire jnc_w = opcode_in == `OP_JNC;
	wire jb_w = opcode_in == `OP_JB;
	wire jnb_w = opcode_in == `OP_JNB;
	wire jbc_w = opcode_in == `OP_JBC;
	wire abs_w = (opcode_in[4:0] == `OP_ACALL_LOW) || (opcode_in[4:0] == `OP_AJMP_LOW);
	wire long_w = (opcode_in == `OP_LCALL) || (opcode_in == `OP_LJMP);
	wire ret_w = (opcode_in == `OP_RET) || (opcode_in == `OP_RETI);
	wire sjmp_w = opcode_in == `OP_SJMP;
	wire jmp_ind_w = opcode_in == `OP_JMP_IND;
	wire jz_w = opcode_in == `OP_JZ;
	wire jnz_w = opcode_in == `OP_JNZ;
	wire cjne_dir_w = opcode_in == `OP_CJNE_DIR;
	wire cjne_imm_w = opcode_in == `OP_CJNE_IMM;
	wire cjne_ind_w = op_even == `OP_CJNE_IND;
	wire cjne_reg_w = op_bank == `OP_CJNE_REG;
	wire djnz_reg_w = op_bank == `OP_DJNZ_REG;
	wire djnz_dir_w = opcode_in == `OP_DJNZ_DIR;
	wire nop_w = (opcode_in == `OP_NOP) || (opcode_in == `OP_NOP_ALT);
	wire movc_w = movc_pc_w || movc_dp_w;
	wire movx_w = movx_rd_w || movx_wr_w;
	wire cond2_w = jc_w || jnc_w || jz_w || jnz_w || djnz_reg_w;
	wire cond3_w = jb_w || jnb_w || jbc_w || cjne_dir_w || cjne_imm_w || cjne_reg_w || djnz_dir_w;
	wire cond_w = cond2_w || cond3_w || cjne_ind_w;
	wire uncond_w = sjmp_w || abs_w || long_w || jmp_ind_w;
	wire rn_form_w = xch_reg_w || cjne_reg_w || djnz_reg_w;
	wire ri_form_w = xch_ind_w || xchd_w || cjne_ind_w;
	wire direct_form_w = stack_w || xch_dir_w || cjne_dir_w || djnz_dir_w;
	wire bit_form_w = bit_op_w || bit_logic_w || jb_w || jnb_w || jbc_w;
	wire listed_w = movc_w || movx_w || stack_w || xch_reg_w || xch_dir_w || ri_form_w || carry_op_w
		|| bit_form_w || cond_w || uncond_w || ret_w || nop_w;

	// ***************************************************
	// Branch condition, length and time
	// ***************************************************
	wire cond_true_w = (jc_w && carry_in) || (jnc_w && !carry_in)
		|| ((jb_w || jbc_w) && bit_value_in) || (jnb_w && !bit_value_in)
		|| (jz_w && acc_in == 8'h00) || (jnz_w && acc_in != 8'h00)
		|| (cjne_dir_w && acc_in != operand_value_in) || (cjne_imm_w && acc_in != operand1_in)
		|| ((cjne_reg_w || cjne_ind_w) && operand_value_in != operand1_in)
		|| ((djnz_reg_w || djnz_dir_w) && operand_value_in != `DJNZ_LAST);
	wire taken_w = cond_w ? cond_true_w : uncond_w;
	wire three_byte_w = cond3_w || cjne_ind_w || long_w;
	wire two_byte_w = stack_w || xch_dir_w || bit_form_w || cond2_w || abs_w || sjmp_w;
	bytes_t bytes_w;
	assign bytes_w = three_byte_w ? 2'h3 : (two_byte_w ? 2'h2 : 2'h1);
	cycles_t base_cycles_w;
	assign base_cycles_w =
		movc_w ? `CYC_MOVC :
		movx_w ? `CYC_MOVX :
		stack_w ? `CYC_STACK :
		xch_reg_w ? `CYC_XCH_REG :
		(xch_dir_w || ri_form_w) && !cjne_ind_w ? `CYC_XCH_MEM :
		carry_op_w ? `CYC_CARRY :
		(bit_op_w || bit_logic_w) ? `CYC_BIT_DIR :
		cond2_w ? `CYC_REL2 :
		cond3_w ? `CYC_REL3 :
		cjne_ind_w ? `CYC_CJNE_IND :
		abs_w ? `CYC_ABS :
		long_w ? `CYC_LONG :
		sjmp_w ? `CYC_SJMP :
		jmp_ind_w ? `CYC_JMP_IND :
		ret_w ? `CYC_RET :
		nop_w ? `CYC_NOP : `CYC_ONE;
	cycles_t cycles_w;
	assign cycles_w = base_cycles_w + ((cond_w && cond_true_w) ? `CYC_TAKEN_EXTRA : 3'h0);

	// ***************************************************
	// Addresses
	// ***************************************************
	addr_t pc_next_w;
	addr_t rel_target_w;
	addr_t target_w;
	addr_t code_addr_w;
	addr_t movx_addr_w;
	byte_t reg_addr_w;
	byte_t bit_byte_w;
	byte_t data_addr_w;
	assign pc_next_w = instr_addr_in + {14'h0000, bytes_w};
	assign rel_target_w = add_offset(pc_next_w, three_byte_w ? operand2_in : operand1_in, 1'b1);
	assign target_w =
		abs_w ? {pc_next_w[15:11], opcode_in[7:5], operand1_in} :
		long_w ? {operand1_in, operand2_in} :
		jmp_ind_w ? add_offset(data_pointer_in, acc_in, 1'b0) :
		(sjmp_w || cond_w) ? rel_target_w : pc_next_w;
	assign code_addr_w = movc_pc_w ? add_offset(pc_next_w, acc_in, 1'b0)
		: add_offset(data_pointer_in, acc_in, 1'b0);
	assign movx_addr_w = movx_dp_w ? data_pointer_in : {8'h00, ri_value_in};
	wire movx_in_flash_w = movx_addr_w <= `FLASH_TOP;
	wire flash_write_w = movx_wr_w && program_store_control_in[`PSC_WRITE_EN_BIT] && movx_in_flash_w;
	wire factory_w = (movc_w && code_addr_w >= `FACTORY_BASE && code_addr_w <= `FLASH_TOP)
		|| (movx_w && movx_addr_w >= `FACTORY_BASE && movx_in_flash_w);
	// Register bank sits in the low 32 bytes
	assign reg_addr_w = {3'h0, bank_select_high_in, bank_select_low_in,
		rn_form_w ? opcode_in[2:0] : {2'h0, opcode_in[0]}};
	// Bits below 0x80 live in the bit area, above on special register byte boundaries
	assign bit_byte_w = operand1_in[`SFR_SPACE_BIT] ? {operand1_in[7:3], 3'h0}
		: `BIT_AREA_BASE + {4'h0, operand1_in[6:3]};
	assign data_addr_w = (direct_form_w ? operand1_in : 8'h00) | (bit_form_w ? bit_byte_w : 8'h00)
		| (ri_form_w ? ri_value_in : 8'h00) | (rn_form_w ? reg_addr_w : 8'h00);
	wire data_sfr_w = (direct_form_w || bit_form_w) && operand1_in[`SFR_SPACE_BIT];

	// ***************************************************
	// Execution sequencer
	// ***************************************************
	exec_state_t state_ff, nxt_state;
	cycles_t cnt_ff, nxt_cnt;
	logic ready_ff, nxt_ready;
	logic done_ff, nxt_done;
	wire accept_w = instr_valid_in && ready_ff;
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_ready = ready_ff;
		nxt_done = 1'b0;
		case (state_ff)
			ST_IDLE:
			begin
				nxt_ready = 1'b1;
			end
			ST_EXEC:
			begin
				nxt_cnt = (cnt_ff == 3'h0) ? 3'h0 : cnt_ff - 3'h1;
				nxt_done = cnt_ff == 3'h1;
				nxt_ready = cnt_ff <= 3'h1;
				if (cnt_ff == 3'h0)
					nxt_state = ST_IDLE;
			end
			default:
			begin
				nxt_state = ST_IDLE;
				nxt_ready = 1'b1;
			end
		endcase
		// Next instruction may be taken in the last cycle of the current one
		if (accept_w)
		begin
			nxt_state = ST_EXEC;
			nxt_cnt = cycles_w - 3'h1;
			nxt_done = cycles_w == 3'h1;
			nxt_ready = cycles_w == 3'h1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_ff <= ST_IDLE;
			cnt_ff <= 3'h0;
			ready_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			ready_ff <= nxt_ready;
			done_ff <= nxt_done;
		end
	end

	// ***************************************************
	// Decoded results, held until the next instruction
	// ***************************************************
	logic [15:0] flags_ff;
	addr_t target_ff, code_addr_ff, movx_addr_ff, pc_next_ff;
	byte_t data_addr_ff;
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			flags_ff <= 16'h0000;
			target_ff <= 16'h0000;
			code_addr_ff <= 16'h0000;
			movx_addr_ff <= 16'h0000;
			pc_next_ff <= 16'h0000;
			data_addr_ff <= 8'h00;
		end
		else if (accept_w)
		begin
			flags_ff <= {!listed_w, nop_w, xchd_w, bytes_w, cycles_w, taken_w, movc_w, movx_rd_w, movx_wr_w,
				flash_write_w, factory_w, data_sfr_w, jbc_w && cond_true_w};
			target_ff <= target_w;
			code_addr_ff <= code_addr_w;
			movx_addr_ff <= movx_addr_w;
			pc_next_ff <= pc_next_w;
			data_addr_ff <= data_addr_w;
		end
	end

	assign ready_out = ready_ff;
	assign done_out = done_ff;
	assign {unlisted_out, nop_out, low_nibble_xch_out, instr_bytes_out, instr_cycles_out, branch_taken_out,
		code_read_out, movx_read_out, movx_write_out, flash_write_out, factory_area_out, data_sfr_out,
		bit_clear_out} = flags_ff;
	assign target_addr_out = target_ff;
	assign code_addr_out = code_addr_ff;
	assign movx_addr_out = movx_addr_ff;
	assign data_addr_out = data_addr_ff;

	// ***************************************************
	// Assertions
	// ***************************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	a_nop_one_cycle:
		assert property (accept_w && nop_w |=> done_ff && nop_out) else $error("nop not one cycle");
	a_sjmp_three_cycles:
		assert property (accept_w && sjmp_w |=> !done_ff ##1 !done_ff ##1 done_ff) else $error("sjmp length");
	a_movx_three_cycles:
		assert property (accept_w && movx_w |=> !done_ff [*2] ##1 done_ff) else $error("movx length");
	a_stack_two_cycles:
		assert property (accept_w && stack_w |=> !done_ff ##1 done_ff && instr_bytes_out == 2'h2)
		else $error("push or pop length");
	a_long_four_cycles:
		assert property (accept_w && long_w |=> instr_cycles_out == 3'h4 && target_addr_out == {$past(operand1_in),
			$past(operand2_in)}) else $error("long jump");
	a_jc_taken_time:
		assert property (accept_w && jc_w |=> instr_cycles_out == ($past(carry_in) ? 3'h3 : 3'h2))
		else $error("jc timing");
	a_cjne_ind_time:
		assert property (accept_w && cjne_ind_w |=> instr_cycles_out == (branch_taken_out ? 3'h5 : 3'h4))
		else $error("cjne indirect timing");
	a_abs_same_page:
		assert property (accept_w && abs_w |=> target_addr_out[15:11] == pc_next_ff[15:11] && branch_taken_out
			&& target_addr_out[10:0] == {$past(opcode_in[7:5]), $past(operand1_in)}) else $error("absolute target");
	a_rel_target_sum:
		assert property (accept_w && sjmp_w |=> target_addr_out == pc_next_ff + {{8{$past(operand1_in[7])}},
			$past(operand1_in)}) else $error("relative target");
	a_flash_write_gate:
		assert property (accept_w && movx_wr_w && !program_store_control_in[0] |=> movx_write_out && !flash_write_out)
		else $error("flash write without enable");
	a_direct_sfr_split:
		assert property (accept_w && direct_form_w |=> data_sfr_out == $past(operand1_in[7])) else $error("direct space");
	a_jbc_clear_bit:
		assert property (accept_w && jbc_w |=> bit_clear_out == branch_taken_out && instr_cycles_out ==
			(branch_taken_out ? 3'h4 : 3'h3)) else $error("jbc clear");
	c_taken_branch: cover property (accept_w && cond_w && cond_true_w ##1 branch_taken_out);
	c_flash_write: cover property (accept_w && flash_write_w);
	c_cjne_five: cover property (accept_w && cjne_ind_w && cond_true_w);
	c_nop_alt: cover property (accept_w && opcode_in == `OP_NOP_ALT ##1 accept_w);
endmodule

/* cpu_timing_defines.svh */
`ifndef CPU_TIMING_DEFINES_SVH
`define CPU_TIMING_DEFINES_SVH

// ***************************************************
// Execution times in system clock cycles
// ***************************************************
`define CYC_ONE 3'h1
`define CYC_MOVC 3'h3
`define CYC_MOVX 3'h3
`define CYC_STACK 3'h2
`define CYC_XCH_REG 3'h1
`define CYC_XCH_MEM 3'h2
`define CYC_CARRY 3'h1
`define CYC_BIT_DIR 3'h2
`define CYC_REL2 3'h2
`define CYC_REL3 3'h3
`define CYC_CJNE_IND 3'h4
`define CYC_ABS 3'h3
`define CYC_LONG 3'h4
`define CYC_SJMP 3'h3
`define CYC_JMP_IND 3'h3
`define CYC_RET 3'h5
`define CYC_NOP 3'h1
`define CYC_TAKEN_EXTRA 3'h1

// ***************************************************
// Memory map and field positions
// ***************************************************
`define FLASH_TOP 16'h1FFF
`define FACTORY_BASE 16'h1E00
`define BIT_AREA_BASE 8'h20
`define SFR_SPACE_BIT 3'h7
`define PSC_WRITE_EN_BIT 3'h0
`define DJNZ_LAST 8'h01

// ***************************************************
// Opcodes
// ***************************************************
`define OP_NOP 8'h00
`define OP_NOP_ALT 8'hA5
`define OP_MOVC_PC 8'h83
`define OP_MOVC_DP 8'h93
`define OP_MOVX_RD_RI 8'hE2
`define OP_MOVX_WR_RI 8'hF2
`define OP_MOVX_RD_DP 8'hE0
`define OP_MOVX_WR_DP 8'hF0
`define OP_PUSH 8'hC0
`define OP_POP 8'hD0
`define OP_XCH_REG 8'hC8
`define OP_XCH_DIR 8'hC5
`define OP_XCH_IND 8'hC6
`define OP_XCHD 8'hD6
`define OP_CLR_C 8'hC3
`define OP_SETB_C 8'hD3
`define OP_CPL_C 8'hB3
`define OP_CLR_BIT 8'hC2
`define OP_SETB_BIT 8'hD2
`define OP_CPL_BIT 8'hB2
`define OP_ANL_C_BIT 8'h82
`define OP_ANL_C_NBIT 8'hB0
`define OP_ORL_C_BIT 8'h72
`define OP_ORL_C_NBIT 8'hA0
`define OP_MOV_C_BIT 8'hA2
`define OP_MOV_BIT_C 8'h92
`define OP_JC 8'h40
`define OP_JNC 8'h50
`define OP_JB 8'h20
`define OP_JNB 8'h30
`define OP_JBC 8'h10
`define OP_ACALL_LOW 5'h11
`define OP_AJMP_LOW 5'h01
`define OP_LCALL 8'h12
`define OP_LJMP 8'h02
`define OP_RET 8'h22
`define OP_RETI 8'h32
`define OP_SJMP 8'h80
`define OP_JMP_IND 8'h73
`define OP_JZ 8'h60
`define OP_JNZ 8'h70
`define OP_CJNE_DIR 8'hB5
`define OP_CJNE_IMM 8'hB4
`define OP_CJNE_IND 8'hB6
`define OP_CJNE_REG 8'hB8
`define OP_DJNZ_REG 8'hD8
`define OP_DJNZ_DIR 8'hD5

`endif

/* cpu_timing_pkg.sv */
package cpu_timing_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] addr_t;
	typedef logic [2:0] cycles_t;
	typedef logic [1:0] bytes_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} exec_state_t;
endpackage

/* data_memory_model.sv */
`timescale 1ns/100ps
module data_memory_model (
	input wire cpu_timing_pkg::byte_t opcode_in,
	input wire logic bank_select_low_in,
	input wire logic bank_select_high_in,
	output cpu_timing_pkg::byte_t ri_value_out
);
	import cpu_timing_pkg::*;
	// ***************************************************
	// Register banks in low data memory
	// ***************************************************
	byte_t ram [0:255];
	byte_t reg_addr;
	// Rn sits at bank * 8 + n; the pointer register is R0 or R1
	assign reg_addr = {3'h0, bank_select_high_in, bank_select_low_in, 2'h0, opcode_in[0]};
	assign ri_value_out = ram[reg_addr];
	// Contents are address plus 0x80, so every pointer aims into upper RAM
	initial
	begin
		for (int i = 0; i < 256; i++)
			ram[i] = 8'(i) + 8'h80;
	end
endmodule

/* tb_cpu_instruction_timing.sv */
`timescale 1ns/100ps
module tb_cpu_instruction_timing;
	import cpu_timing_pkg::*;
	// ***************************************************
	// Stimulus and observation
	// ***************************************************
	logic clk_sys_in, rst_n_in, instr_valid_in, carry_in, bit_value_in, bank_select_low_in, bank_select_high_in;
	byte_t opcode_in, operand1_in, operand2_in, acc_in, operand_value_in, ri_value_in, program_store_control_in;
	addr_t instr_addr_in, data_pointer_in;
	logic ready_out, done_out, branch_taken_out, code_read_out, movx_read_out, movx_write_out, flash_write_out;
	logic factory_area_out, data_sfr_out, bit_clear_out, low_nibble_xch_out, nop_out, unlisted_out;
	bytes_t instr_bytes_out;
	cycles_t instr_cycles_out;
	addr_t target_addr_out, code_addr_out, movx_addr_out;
	byte_t data_addr_out;
	int miscompares = 0;
	int samples_checked = 0;
	int cycle_count = 0;
	instruction_timing_decoder u_dut (.clk_sys_in, .rst_n_in, .instr_valid_in, .opcode_in, .operand1_in,
		.operand2_in, .instr_addr_in, .acc_in, .data_pointer_in, .carry_in, .bit_value_in, .operand_value_in,
		.ri_value_in, .bank_select_low_in, .bank_select_high_in, .program_store_control_in, .ready_out,
		.done_out, .instr_bytes_out, .instr_cycles_out, .branch_taken_out, .target_addr_out, .code_read_out,
		.code_addr_out, .movx_read_out, .movx_write_out, .flash_write_out, .movx_addr_out, .factory_area_out,
		.data_addr_out, .data_sfr_out, .bit_clear_out, .low_nibble_xch_out, .nop_out, .unlisted_out);
	data_memory_model u_mem (.opcode_in, .bank_select_low_in, .bank_select_high_in, .ri_value_out(ri_value_in));
	initial
	begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	// Every scenario together needs a few hundred cycles
	always @(posedge clk_sys_in)
	begin
		cycle_count++;
		if (cycle_count == 3000)
		begin
			miscompares++;
			stop_test();
		end
	end
	// ***************************************************
	// Shared tasks
	// ***************************************************
	task automatic ck(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wait_accept();
		int n;
		n = 0;
		@(posedge clk_sys_in);
		while (ready_out !== 1'b1 && n < 20)
		begin
			@(posedge clk_sys_in);
			n++;
		end
	endtask
	// Values read just after an edge are the ones the previous edge stored
	task automatic run(input byte_t op, input byte_t o1, input byte_t o2, input addr_t at,
		input int nb, input int nc, input logic tk, input addr_t tgt);
		int n;
		opcode_in <= op;
		operand1_in <= o1;
		operand2_in <= o2;
		instr_addr_in <= at;
		instr_valid_in <= 1'b1;
		wait_accept();
		instr_valid_in <= 1'b0;
		@(posedge clk_sys_in);
		ck(16'(instr_bytes_out), 16'(nb), "length");
		ck(16'(branch_taken_out), 16'(tk), "taken");
		ck(target_addr_out, tgt, "target");
		ck(16'(instr_cycles_out), 16'(nc), "cycle field");
		n = 1;
		while (done_out !== 1'b1 && n < 8)
		begin
			@(posedge clk_sys_in);
			n++;
		end
		ck(16'(n), 16'(nc), "cycles to done");
	endtask
	task stop_test();
		$display("checked %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ***************************************************
	// Scenarios
	// ***************************************************
	task automatic test_transfers();
		byte_t ops [4] = '{8'hE2, 8'hF2, 8'hE0, 8'hF0};
		acc_in <= 8'h20;
		run(8'h83, 8'h00, 8'h00, 16'h1DF0, 1, 3, 1'b0, 16'h1DF1);
		ck(16'(code_read_out), 16'h0001, "code read");
		ck(code_addr_out, 16'h1E11, "code addr");
		ck(16'(factory_area_out), 16'h0001, "code factory");
		run(8'h93, 8'h00, 8'h00, 16'h0040, 1, 3, 1'b0, 16'h0041);
		ck(16'(code_read_out), 16'h0001, "code read dp");
		ck(code_addr_out, 16'h0020, "code addr dp");
		data_pointer_in <= 16'h1E10;
		program_store_control_in <= 8'h01;
		foreach (ops[i])
		begin
			run(ops[i], 8'h00, 8'h00, 16'h0060, 1, 3, 1'b0, 16'h0061);
			ck(movx_addr_out, ops[i][1] ? 16'h0080 : 16'h1E10, "movx addr");
			ck(16'(movx_write_out), 16'(ops[i][4]), "movx write");
			ck(16'(movx_read_out), 16'(!ops[i][4]), "movx read");
			ck(16'(flash_write_out), 16'(ops[i][4]), "flash write");
			ck(16'(factory_area_out), 16'(!ops[i][1]), "factory");
		end
		// Every bit but the enable set: still no write
		program_store_control_in <= 8'hFE;
		run(8'hF0, 8'h00, 8'h00, 16'h0060, 1, 3, 1'b0, 16'h0061);
		ck(16'(flash_write_out), 16'h0000, "write disabled");
		program_store_control_in <= 8'h01;
		data_pointer_in <= 16'h2000;
		run(8'hF0, 8'h00, 8'h00, 16'h0060, 1, 3, 1'b0, 16'h0061);
		ck(16'(flash_write_out), 16'h0000, "past flash");
		$display("transfers finished");
	endtask
	task automatic test_stack_xch();
		bank_select_low_in <= 1'b1;
		bank_select_high_in <= 1'b1;
		run(8'hC0, 8'h80, 8'h00, 16'h0010, 2, 2, 1'b0, 16'h0012);
		ck(16'(data_addr_out), 16'h0080, "push addr");
		ck(16'(data_sfr_out), 16'h0001, "push sfr");
		run(8'hD0, 8'h7F, 8'h00, 16'h0010, 2, 2, 1'b0, 16'h0012);
		ck(16'(data_sfr_out), 16'h0000, "pop ram");
		run(8'hCA, 8'h00, 8'h00, 16'h0010, 1, 1, 1'b0, 16'h0011);
		ck(16'(data_addr_out), 16'h001A, "bank reg");
		run(8'hC5, 8'h30, 8'h00, 16'h0010, 2, 2, 1'b0, 16'h0012);
		run(8'hC7, 8'h00, 8'h00, 16'h0010, 1, 2, 1'b0, 16'h0011);
		ck(16'(data_addr_out), 16'h0099, "indirect addr");
		ck(16'(data_sfr_out), 16'h0000, "indirect upper");
		run(8'hD7, 8'h00, 8'h00, 16'h0010, 1, 2, 1'b0, 16'h0011);
		ck(16'(low_nibble_xch_out), 16'h0001, "nibble");
		$display("stack and exchange finished");
	endtask
	task automatic test_bits();
		byte_t ops [12] = '{8'hC3, 8'hD3, 8'hB3, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92};
		foreach (ops[i])
			run(ops[i], 8'h21, 8'h00, 16'h0100, i < 3 ? 1 : 2, i < 3 ? 1 : 2, 1'b0, i < 3 ? 16'h0101 : 16'h0102);
		carry_in <= 1'b1;
		run(8'h40, 8'h10, 8'h00, 16'h0200, 2, 3, 1'b1, 16'h0212);
		run(8'h50, 8'h10, 8'h00, 16'h0200, 2, 2, 1'b0, 16'h0212);
		bit_value_in <= 1'b1;
		run(8'h20, 8'h21, 8'h80, 16'h0300, 3, 4, 1'b1, 16'h0283);
		run(8'h30, 8'h21, 8'h80, 16'h0300, 3, 3, 1'b0, 16'h0283);
		run(8'h10, 8'h21, 8'h80, 16'h0300, 3, 4, 1'b1, 16'h0283);
		ck(16'(bit_clear_out), 16'h0001, "bit clear");
		bit_value_in <= 1'b0;
		run(8'h10, 8'h21, 8'h80, 16'h0300, 3, 3, 1'b0, 16'h0283);
		ck(16'(bit_clear_out), 16'h0000, "no clear");
		$display("bits finished");
	endtask
	task automatic test_jumps();
		run(8'hE1, 8'h34, 8'h00, 16'h07FE, 2, 3, 1'b1, 16'h0F34);
		run(8'hF1, 8'h34, 8'h00, 16'h07FE, 2, 3, 1'b1, 16'h0F34);
		run(8'h02, 8'h12, 8'h34, 16'h1000, 3, 4, 1'b1, 16'h1234);
		run(8'h12, 8'hFF, 8'hF0, 16'h1000, 3, 4, 1'b1, 16'hFFF0);
		run(8'h80, 8'hFE, 8'h00, 16'h0100, 2, 3, 1'b1, 16'h0100);
		acc_in <= 8'h80;
		data_pointer_in <= 16'h1F90;
		run(8'h73, 8'h00, 8'h00, 16'h0500, 1, 3, 1'b1, 16'h2010);
		acc_in <= 8'h00;
		run(8'h60, 8'h05, 8'h00, 16'h0400, 2, 3, 1'b1, 16'h0407);
		run(8'h70, 8'h05, 8'h00, 16'h0400, 2, 2, 1'b0, 16'h0407);
		$display("jumps finished");
	endtask
	task automatic test_compare();
		acc_in <= 8'h33;
		operand_value_in <= 8'h44;
		run(8'hB5, 8'h40, 8'hF0, 16'h0600, 3, 4, 1'b1, 16'h05F3);
		run(8'hB4, 8'h33, 8'hF0, 16'h0600, 3, 3, 1'b0, 16'h05F3);
		run(8'hB6, 8'h45, 8'h10, 16'h0600, 3, 5, 1'b1, 16'h0613);
		run(8'hB7, 8'h44, 8'h10, 16'h0600, 3, 4, 1'b0, 16'h0613);
		run(8'hB9, 8'h44, 8'h10, 16'h0600, 3, 3, 1'b0, 16'h0613);
		operand_value_in <= 8'h01;
		run(8'hD8, 8'hFE, 8'h00, 16'h0700, 2, 2, 1'b0, 16'h0700);
		run(8'hD5, 8'h30, 8'hFD, 16'h0700, 3, 3, 1'b0, 16'h0700);
		operand_value_in <= 8'h00;
		run(8'hDF, 8'hFE, 8'h00, 16'h0700, 2, 3, 1'b1, 16'h0700);
		run(8'hD5, 8'h30, 8'hFD, 16'h0700, 3, 4, 1'b1, 16'h0700);
		$display("compare finished");
	endtask
	task automatic test_nop_busy();
		int n;
		run(8'h00, 8'h00, 8'h00, 16'h0800, 1, 1, 1'b0, 16'h0801);
		ck(16'(nop_out), 16'h0001, "nop");
		run(8'hA5, 8'h00, 8'h00, 16'h0800, 1, 1, 1'b0, 16'h0801);
		ck(16'(nop_out), 16'h0001, "alt nop");
		run(8'h22, 8'h00, 8'h00, 16'h0800, 1, 5, 1'b0, 16'h0801);
		run(8'h04, 8'h00, 8'h00, 16'h0800, 1, 1, 1'b0, 16'h0801);
		ck(16'(unlisted_out), 16'h0001, "unlisted");
		// A request held high while busy must not disturb the jump
		opcode_in <= 8'h80;
		operand1_in <= 8'hFE;
		instr_addr_in <= 16'h0100;
		instr_valid_in <= 1'b1;
		wait_accept();
		opcode_in <= 8'h00;
		repeat (2) @(posedge clk_sys_in);
		ck(target_addr_out, 16'h0100, "busy target");
		@(posedge clk_sys_in);
		ck(16'(done_out), 16'h0001, "jump done");
		n = 0;
		@(posedge clk_sys_in);
		while (nop_out !== 1'b1 && n < 4)
		begin
			@(posedge clk_sys_in);
			n++;
		end
		instr_valid_in <= 1'b0;
		ck(16'(nop_out), 16'h0001, "queued nop");
		repeat (3) @(posedge clk_sys_in);
		$display("nop and busy finished");
	endtask
	// ***************************************************
	// Main sequence
	// ***************************************************
	initial
	begin
		rst_n_in = 1'b0;
		instr_valid_in = 1'b0;
		opcode_in = 8'h00;
		operand1_in = 8'h00;
		operand2_in = 8'h00;
		instr_addr_in = 16'h0000;
		acc_in = 8'h00;
		data_pointer_in = 16'h0000;
		carry_in = 1'b0;
		bit_value_in = 1'b0;
		operand_value_in = 8'h00;
		bank_select_low_in = 1'b0;
		bank_select_high_in = 1'b0;
		program_store_control_in = 8'h00;
		repeat (4) @(posedge clk_sys_in);
		ck(16'(ready_out), 16'h0000, "ready in reset");
		rst_n_in <= 1'b1;
		test_transfers();
		test_stack_xch();
		test_bits();
		test_jumps();
		test_compare();
		test_nop_busy();
		stop_test();
	end
endmodule
